// ==== scoc_ctrl.sv ====
`timescale 1ns/1ps
// Functional notes
// - Enabled hold input opens the loop unless external clock is selected
// - External clock select uses external clock
// - Phase adjust still works with external clock
// - Invert input shifts sampling half period
// - Invert toggled per frame, half rate
// - Line sync aligned with sampled data
// - Frame sync is delayed input vertical sync
// - Green slicer result shown on output
// - Phase adjust shifts clock, data, sync together
module scoc_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hold_enable,
    input wire logic pll_hold_in,
    input wire logic ext_clock_select,
    input wire logic external_sample_clock_in,
    input wire logic sample_clock_invert_in,
    input wire logic ref_line_sync_in,
    input wire logic vertical_sync_in,
    input wire logic green_slicer_in,
    input wire logic [7:0] pixel_in,
    input wire logic [7:0] phase_adjust,
    output logic output_data_clock,
    output logic [7:0] pixel_out,
    output logic line_sync_out,
    output logic frame_sync_out,
    output logic green_sync_slicer_out,
    output logic loop_open_out
);
    import scoc_pkg::*;

    // ------------------------------------------------------------
    // Loop mode
    // ------------------------------------------------------------
    scoc_loop_t loop_q;
    scoc_loop_t loop_d;
    logic [7:0] nco_q;
    logic ref_q;
    logic ref_edge;
    logic sample_tick;
    logic src_clk;
    logic [3:0] ext_dly_q;
    logic [PIXEL_PIPE_DEPTH-1:0] line_pipe_q;
    logic [7:0] pixel_pipe_q [PIXEL_PIPE_DEPTH];
    logic [FRAME_SYNC_DELAY-1:0] frame_pipe_q;

    always_comb begin
        if (ext_clock_select) begin
            loop_d = SCOC_LOOP_EXT;
        end else if (hold_enable && pll_hold_in) begin
            loop_d = SCOC_LOOP_OPEN;
        end else begin
            loop_d = SCOC_LOOP_LOCKED;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            loop_q <= SCOC_LOOP_LOCKED;
        end else begin
            loop_q <= loop_d;
        end
    end

    assign ref_edge = ref_line_sync_in && !ref_q;

    // ------------------------------------------------------------
    // Clock generator
    // ------------------------------------------------------------
    // The accumulator free-runs except with external clock, where it holds; reference edges realign it only when locked,
    // so an open loop keeps its last frequency instead of chasing bad pulses.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nco_q <= PIXEL_RESET;
            ref_q <= RESET_LOW;
            ext_dly_q <= '0;
        end else begin
            ref_q <= ref_line_sync_in;
            ext_dly_q <= {ext_dly_q[2:0], external_sample_clock_in};
            case (loop_d)
                SCOC_LOOP_LOCKED: begin
                    nco_q <= ref_edge ? PIXEL_RESET : nco_q + PHASE_STEP;
                end
                SCOC_LOOP_OPEN: begin
                    nco_q <= nco_q + PHASE_STEP;
                end
                SCOC_LOOP_EXT: begin
                    nco_q <= nco_q;
                end
                default: begin
                    nco_q <= PIXEL_RESET;
                end
            endcase
        end
    end

    // phase adjust applies to either source
    // one phase offset for clock, data and sync
    // toggled per frame by the controller
    always_comb begin
        if (loop_q == SCOC_LOOP_EXT) begin
            // External clock has no phase to compare against, so the
            // top phase bits pick a delay tap in system clock steps instead
            src_clk = ext_dly_q[phase_adjust[7:6]];
        end else begin
            src_clk = nco_q[7] ^ (nco_q >= phase_adjust);
        end
        src_clk = src_clk ^ sample_clock_invert_in;
    end

    logic clk_prev_q;
    assign sample_tick = src_clk && !clk_prev_q;

    // ------------------------------------------------------------
    // Sampled data path
    // ------------------------------------------------------------
    // line sync travels with data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clk_prev_q <= RESET_LOW;
            output_data_clock <= RESET_LOW;
            line_pipe_q <= '0;
            for (int i = 0; i < PIXEL_PIPE_DEPTH; i++) begin
                pixel_pipe_q[i] <= PIXEL_RESET;
            end
        end else begin
            clk_prev_q <= src_clk;
            output_data_clock <= src_clk;
            if (sample_tick) begin
                line_pipe_q <= {line_pipe_q[PIXEL_PIPE_DEPTH-2:0], ref_line_sync_in};
                pixel_pipe_q[0] <= pixel_in;
                for (int i = 1; i < PIXEL_PIPE_DEPTH; i++) begin
                    pixel_pipe_q[i] <= pixel_pipe_q[i-1];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pixel_out <= PIXEL_RESET;
            line_sync_out <= RESET_LOW;
            loop_open_out <= RESET_LOW;
        end else begin
            pixel_out <= pixel_pipe_q[PIXEL_PIPE_DEPTH-1];
            line_sync_out <= line_pipe_q[PIXEL_PIPE_DEPTH-1];
            loop_open_out <= (loop_d == SCOC_LOOP_OPEN);
        end
    end

    // ------------------------------------------------------------
    // Frame sync and slicer
    // ------------------------------------------------------------
    // delayed vertical sync
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frame_pipe_q <= '0;
            frame_sync_out <= RESET_LOW;
            green_sync_slicer_out <= RESET_LOW;
        end else begin
            frame_pipe_q <= {frame_pipe_q[FRAME_SYNC_DELAY-2:0], vertical_sync_in};
            frame_sync_out <= frame_pipe_q[FRAME_SYNC_DELAY-1];
            green_sync_slicer_out <= green_slicer_in;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_hold_opens_loop: assert property (@(posedge clk_sys) disable iff (rst)
        (hold_enable && pll_hold_in && !ext_clock_select) |=> loop_open_out)
        else $error("hold did not open loop");
    chk_hold_disabled_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        !hold_enable |=> !loop_open_out)
        else $error("hold acted while disabled");
    chk_ext_clock_used: assert property (@(posedge clk_sys) disable iff (rst)
        (ext_clock_select && phase_adjust[7:6] == 2'h1) ##1 (ext_clock_select && $stable(phase_adjust))
        |-> src_clk == ($past(ext_dly_q[0]) ^ sample_clock_invert_in))
        else $error("external clock not selected");
    chk_frame_sync_delay: assert property (@(posedge clk_sys) disable iff (rst)
        ##5 frame_sync_out == $past(vertical_sync_in, 5))
        else $error("frame sync delay wrong");
    chk_slicer_passthru: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 green_sync_slicer_out == $past(green_slicer_in))
        else $error("slicer output wrong");
    chk_data_clock_follows: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 output_data_clock == $past(src_clk))
        else $error("data clock not aligned");
    chk_invert_flips_clock: assert property (@(posedge clk_sys) disable iff (rst)
        (loop_q == SCOC_LOOP_EXT && $past(loop_q) == SCOC_LOOP_EXT && $stable(phase_adjust)
        && $stable(ext_dly_q[phase_adjust[7:6]]) && $changed(sample_clock_invert_in)) |-> $changed(src_clk))
        else $error("invert not applied");
    chk_line_sync_aligned: assert property (@(posedge clk_sys) disable iff (rst)
        !sample_tick ##1 1'b1 |-> $stable(line_pipe_q))
        else $error("line sync moved off tick");
    chk_open_ignores_ref: assert property (@(posedge clk_sys) disable iff (rst)
        (loop_d == SCOC_LOOP_OPEN) |=> nco_q == $past(nco_q) + PHASE_STEP)
        else $error("open loop followed reference");
    chk_locked_realign: assert property (@(posedge clk_sys) disable iff (rst)
        (loop_d == SCOC_LOOP_LOCKED && ref_edge) |=> nco_q == PIXEL_RESET)
        else $error("locked loop missed reference");
    chk_ext_overrides_hold: assert property (@(posedge clk_sys) disable iff (rst)
        ext_clock_select |=> !loop_open_out)
        else $error("hold acted on external clock");
    chk_pixel_on_tick: assert property (@(posedge clk_sys) disable iff (rst)
        sample_tick |=> pixel_pipe_q[0] == $past(pixel_in))
        else $error("pixel not taken on tick");
    chk_sync_on_tick: assert property (@(posedge clk_sys) disable iff (rst)
        sample_tick |=> line_pipe_q[0] == $past(ref_line_sync_in))
        else $error("line sync not taken on tick");
endmodule

// ==== scoc_pkg.sv ====
package scoc_pkg;
    // Frame sync pipeline depth; frame_sync_out lags vertical_sync_in by this plus one clk_sys cycle
    localparam int unsigned FRAME_SYNC_DELAY = 4;
    // Line sync pipeline depth, matches the pixel data path
    localparam int unsigned PIXEL_PIPE_DEPTH = 2;
    localparam logic [7:0] PIXEL_RESET = 8'h00;
    localparam logic RESET_LOW = 1'b0;
    // Phase step added every clk_sys cycle in the open loop mode, and in locked mode except on reference edges
    localparam logic [7:0] PHASE_STEP = 8'h10;
    typedef enum logic [1:0] {
        SCOC_LOOP_LOCKED = 2'b00,
        SCOC_LOOP_OPEN = 2'b01,
        SCOC_LOOP_EXT = 2'b10
    } scoc_loop_t;
endpackage

// ==== scoc_capture_model.sv ====
`timescale 1ns/1ps
// Downstream capture logic plus an external sample clock source
module scoc_capture_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic line_sync_out,
    input wire logic [7:0] pixel_out,
    output logic ext_clk,
    output logic [7:0] captured
);
    logic [1:0] div_q;
    // Slow external clock so each level spans several system cycles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_q <= 2'h0;
            ext_clk <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                ext_clk <= ~ext_clk;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (line_sync_out) begin
            captured <= pixel_out;
        end
    end
endmodule

// ==== tb_sample_clock_and_sync_out_ctrl.sv ====
`timescale 1ns/1ps
module tb_sample_clock_and_sync_out_ctrl;
    import scoc_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, hold_en = 1'b0, hold = 1'b0, ext_sel = 1'b0, inv = 1'b0;
    logic ref_ls = 1'b0, vsync = 1'b0, green = 1'b0;
    logic [7:0] pix = 8'h00, phase = 8'h40;
    logic odc, ls, fs, gs, lo, ext_clk;
    logic [7:0] pix_out, captured;
    int n_mismatch = 0, num_checks = 0, cycles = 0, n;
    scoc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .hold_enable(hold_en), .pll_hold_in(hold),
        .ext_clock_select(ext_sel), .external_sample_clock_in(ext_clk), .sample_clock_invert_in(inv),
        .ref_line_sync_in(ref_ls), .vertical_sync_in(vsync), .green_slicer_in(green), .pixel_in(pix),
        .phase_adjust(phase), .output_data_clock(odc), .pixel_out(pix_out), .line_sync_out(ls),
        .frame_sync_out(fs), .green_sync_slicer_out(gs), .loop_open_out(lo));
    scoc_capture_model partner (.clk_sys(clk_sys), .rst(rst), .line_sync_out(ls), .pixel_out(pix_out),
        .ext_clk(ext_clk), .captured(captured));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? fs : (sel == 1 ? gs : lo);
    endfunction
    // Edges from the driving edge until the chosen output reaches lvl, 20 meaning never
    task automatic latency(input int sel, input logic lvl);
        n = 0;
        #1;
        while (pick(sel) !== lvl && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask
    task automatic wait_ls(input logic lvl);
        int k;
        k = 0;
        #1;
        while (ls !== lvl && k < 300) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        check({7'h0, ls}, {7'h0, lvl});
    endtask
    task automatic t_sync();
        @(posedge clk_sys);
        vsync <= 1'b1;
        green <= 1'b1;
        latency(1, 1'b1);
        check(8'(n), 8'h01);
        latency(0, 1'b1);
        check(8'(n), 8'h04);
        @(posedge clk_sys);
        vsync <= 1'b0;
        latency(0, 1'b0);
        check(8'(n), 8'h05);
    endtask
    task automatic t_hold();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            hold_en <= (i != 1);
            ext_sel <= (i == 2);
            hold <= 1'b1;
            latency(2, 1'b1);
            check(8'(n), (i == 0) ? 8'h01 : 8'h14);
            @(posedge clk_sys);
            hold <= 1'b0;
            latency(2, 1'b0);
            check({7'h0, lo}, 8'h00);
        end
    endtask
    task automatic t_hold_frame();
        @(posedge clk_sys);
        hold_en <= 1'b1;
        ext_sel <= 1'b0;
        vsync <= 1'b1;
        latency(0, 1'b1);
        check(8'(n), 8'h05);
        @(posedge clk_sys);
        hold <= fs;
        vsync <= 1'b0;
        latency(2, 1'b1);
        check(8'(n), 8'h01);
        @(posedge clk_sys);
        hold <= 1'b0;
        latency(2, 1'b0);
        check(8'(n), 8'h01);
    endtask
    task automatic t_pixel();
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            ext_sel <= m[1];
            inv <= m[0];
            phase <= (m == 1) ? 8'hC0 : 8'h40;
            ref_ls <= 1'b0;
            wait_ls(1'b0);
            @(posedge clk_sys);
            pix <= 8'(8'h11 * (m + 3));
            ref_ls <= 1'b1;
            wait_ls(1'b1);
            check(pix_out, 8'(8'h11 * (m + 3)));
            @(posedge clk_sys);
            #1;
            check(captured, 8'(8'h11 * (m + 3)));
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Whole run needs well under this many cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check({odc, ls, fs, gs, lo, 3'h0}, 8'h00);
        check(pix_out, PIXEL_RESET);
        t_sync();
        t_hold();
        t_hold_frame();
        t_pixel();
        complete_run();
    end
endmodule
